// ===== hdl/fcl_pkg.sv
// Constants, state encoding and carrier types of the flash configuration loader.
// Assumes a single 25 MHz clock; every time below is turned into cycles at that rate.
package fcl_pkg;

	// Clock
	localparam int CLK_NS = 40;

	// Flash read access time, a least time, so it rounds up
	localparam int FLASH_ACCESS_NS = 100;
	localparam int FLASH_WAIT_INT = (FLASH_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] FLASH_WAIT = 2'(FLASH_WAIT_INT);

	// Low pulse on the configuration start pin, a least time
	localparam int NCONFIG_LOW_NS = 2000;
	localparam int NCONFIG_LOW = (NCONFIG_LOW_NS + CLK_NS - 1) / CLK_NS;

	// Button debounce window, a least time
	localparam int DEBOUNCE_NS = 10_000_000;
	localparam int DEBOUNCE_DEF = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;

	// Longest wait for the target's status or done answer, rounds down
	localparam int TIMEOUT_NS = 1_000_000;
	localparam int TIMEOUT_DEF = TIMEOUT_NS / CLK_NS;

	// Cycles before a freshly synchronised status level is trusted
	localparam logic [19:0] STATUS_GUARD = 20'h0_0008;

	// Widths and sizes
	localparam int TIMER_W = 20;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam logic [23:0] IMAGE_WORDS = 24'h10_0000;
	localparam logic [23:0] PAGE_OFFSET = 24'h00_0000;

	// Image pages and their indicator pattern
	localparam logic [1:0] PAGE_FACTORY = 2'h0;
	localparam logic [1:0] PAGE_USER1 = 2'h1;
	localparam logic [1:0] PAGE_USER2 = 2'h2;
	localparam logic [2:0] IND_ONE = 3'h1;
	localparam logic [2:0] IND_RESET = 3'h6;

	// Positions of the asynchronous inputs in the synchroniser bank
	localparam int PIN_LOAD = 0;
	localparam int PIN_SEL = 1;
	localparam int PIN_USER_SW = 2;
	localparam int PIN_EXT_JTAG = 3;
	localparam int PIN_NSTATUS = 4;
	localparam int PIN_DONE = 5;
	localparam int PIN_COUNT = 6;

	typedef enum logic [2:0] {
		FCL_IDLE = 3'h0,
		FCL_PULSE = 3'h1,
		FCL_WAIT_STATUS = 3'h3,
		FCL_STREAM = 3'h2,
		FCL_FINISH = 3'h6,
		FCL_DONE = 3'h7,
		FCL_ERROR = 3'h5
	} fcl_state_t;

	typedef struct packed {
		logic last;
		logic [DATA_W-1:0] data;
	} fcl_word_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} fcl_flash_req_t;

	typedef struct packed {
		logic nconfig;
		logic dclk;
		logic [DATA_W-1:0] data;
	} fcl_cfg_out_t;

endpackage

// ===== hdl/fcl_fifo.sv
// Word FIFO between the flash reader and the configuration writer.
// Assumes a synchronous clock domain; flush empties it in one cycle.
`timescale 1ns/10ps
module fcl_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic flush,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic full, empty, push, pop;

	assign full = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
	assign empty = (wr_ptr == rd_ptr);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr[PW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (flush) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
		end else begin
			if (push)
				next_wr_ptr = wr_ptr + 1'b1;
			if (pop)
				next_rd_ptr = rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// Storage carries no reset, only the pointers do
	always_ff @(posedge clock) begin
		if (push && !flush)
			mem[wr_ptr[PW-1:0]] <= in_data;
	end

	chk_fifo_full_stall: assert property (@(posedge clock) disable iff (!rst_n)
		(full && !flush) |=> (wr_ptr == $past(wr_ptr)))
		else $error("fifo accepts while full");
	chk_fifo_push_visible: assert property (@(posedge clock) disable iff (!rst_n)
		(push && !flush && empty) |=> out_valid) else $error("pushed word not visible");
endmodule

// ===== hdl/fcl_loader.sv
// Flash configuration loader: reads an image page from parallel flash and
// writes it 16 bits per clock strobe into the target's parallel config port.
// Assumes raw pins on buttons, switches and target status; one 25 MHz clock.
`timescale 1ns/10ps
module fcl_loader #(
	parameter int DEBOUNCE_CYCLES = fcl_pkg::DEBOUNCE_DEF,
	parameter int TIMEOUT_CYCLES = fcl_pkg::TIMEOUT_DEF,
	parameter logic [23:0] IMAGE_LEN = fcl_pkg::IMAGE_WORDS
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Buttons and switches, raw pins
	input wire logic config_load_button_n,
	input wire logic page_select_button_n,
	input wire logic user_image_sw_n,
	input wire logic ext_jtag_present_n,
	// Flash
	output fcl_pkg::fcl_flash_req_t flash_req,
	input wire logic [fcl_pkg::DATA_W-1:0] flash_data,
	// Target configuration port
	output fcl_pkg::fcl_cfg_out_t cfg_out,
	input wire logic cfg_nstatus,
	input wire logic cfg_conf_done,
	// Indicators and chain control
	output logic [2:0] page_indicator,
	output logic load_led,
	output logic config_done_led_n,
	output logic error_led,
	output logic onboard_jtag_en
);
	import fcl_pkg::*;
	logic rst_meta, rst_n;
	logic [PIN_COUNT-1:0] pin_raw, lvl, lvl_d;
	logic load_press, sel_press, sw_on, ext_present, nstatus_s, done_s;
	fcl_state_t state, next_state;
	logic [TIMER_W-1:0] timer, next_timer;
	logic [1:0] page, next_page, cur_page, next_cur_page;
	logic [2:0] settle, next_settle;
	logic [1:0] wr_phase, next_wr_phase, rd_wait, next_rd_wait;
	logic [2:0] next_indicator;
	logic boot_pend, next_boot_pend, go, idle_like, boot_go;
	logic [ADDR_W-1:0] rd_addr, next_rd_addr;
	logic [23:0] rd_left, next_rd_left;
	logic flash_rd, next_flash_rd, wr_last, next_wr_last;
	logic next_load_led, next_done_n, next_error, next_jtag_en;
	fcl_cfg_out_t next_cfg;
	fcl_word_t fifo_in, fifo_out;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;
	// Reset release through two flops
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end
	assign pin_raw = {cfg_conf_done, cfg_nstatus, ext_jtag_present_n,
		user_image_sw_n, page_select_button_n, config_load_button_n};
	// Three-flop synchroniser and stability filter per input pin
	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
		localparam logic [TIMER_W-1:0] LIMIT =
			(i <= PIN_SEL) ? TIMER_W'(DEBOUNCE_CYCLES) : 20'h0_0001;
		// Done pin idles low; starting there avoids a false done after reset
		localparam logic IDLE_LVL = (i == PIN_DONE) ? 1'b0 : 1'b1;
		logic s1, s2, s3, l, next_l;
		logic [TIMER_W-1:0] cnt, next_cnt;
		always_comb begin
			next_cnt = cnt;
			next_l = l;
			if (s2 != s3 || s3 == l) begin
				next_cnt = '0;
			end else if (cnt + 20'h0_0001 >= LIMIT) begin
				next_l = s3;
				next_cnt = '0;
			end else begin
				next_cnt = cnt + 20'h0_0001;
			end
		end
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				{s1, s2, s3, l} <= {4{IDLE_LVL}};
				cnt <= '0;
			end else begin
				{s1, s2, s3} <= {pin_raw[i], s1, s2};
				l <= next_l;
				cnt <= next_cnt;
			end
		end
		assign lvl[i] = l;
	end
	// Buttons pull low when pressed; one pulse on the filtered falling edge
	assign load_press = lvl_d[PIN_LOAD] && !lvl[PIN_LOAD];
	assign sel_press = lvl_d[PIN_SEL] && !lvl[PIN_SEL];
	assign sw_on = !lvl[PIN_USER_SW];
	assign ext_present = !lvl[PIN_EXT_JTAG];
	assign nstatus_s = lvl[PIN_NSTATUS];
	assign done_s = lvl[PIN_DONE];
	assign idle_like = (state == FCL_IDLE) || (state == FCL_DONE) || (state == FCL_ERROR);
	// Boot waits until the switch level has crossed synchroniser and filter
	assign boot_go = idle_like && boot_pend && (settle == 3'h5);
	// Handshakes with the FIFO
	assign fifo_in_valid = (state == FCL_STREAM) && (rd_left != 24'h00_0000)
		&& (rd_wait == FLASH_WAIT);
	assign fifo_in = '{last: (rd_left == 24'h00_0001), data: flash_data};
	assign fifo_out_ready = (state == FCL_STREAM) && (wr_phase == 2'h0);
	assign fifo_flush = (state != FCL_STREAM);
	fcl_fifo #(
		.WIDTH($bits(fcl_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.flush(fifo_flush),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);
	always_comb begin
		next_state = state;
		next_timer = timer;
		next_page = page;
		next_cur_page = cur_page;
		next_settle = settle;
		next_boot_pend = boot_pend;
		next_rd_addr = rd_addr;
		next_rd_left = rd_left;
		next_rd_wait = rd_wait;
		next_wr_phase = wr_phase;
		next_wr_last = wr_last;
		next_cfg = cfg_out;
		go = 1'b0;
		if (sel_press)
			next_page = (page == PAGE_USER2) ? PAGE_FACTORY : page + 2'h1;
		next_indicator = ~(IND_ONE << next_page);
		if (settle != 3'h5)
			next_settle = settle + 3'h1;
		if (boot_go) begin
			go = 1'b1;
			next_boot_pend = 1'b0;
			next_cur_page = sw_on ? PAGE_USER1 : PAGE_FACTORY;
		end else if (idle_like && load_press) begin
			go = 1'b1;
			next_cur_page = page;
		end
		case (state)
			FCL_IDLE, FCL_DONE, FCL_ERROR: begin
				if (go) begin
					next_state = FCL_PULSE;
					next_timer = '0;
					next_cfg.nconfig = 1'b0;
					next_cfg.dclk = 1'b0;
				end
			end
			FCL_PULSE: begin
				next_timer = timer + 20'h0_0001;
				if (timer == TIMER_W'(NCONFIG_LOW - 1)) begin
					next_cfg.nconfig = 1'b1;
					next_state = FCL_WAIT_STATUS;
					next_timer = '0;
				end
			end
			FCL_WAIT_STATUS: begin
				next_timer = timer + 20'h0_0001;
				if (nstatus_s && timer >= STATUS_GUARD) begin
					next_state = FCL_STREAM;
					next_rd_addr = {cur_page, PAGE_OFFSET};
					next_rd_left = IMAGE_LEN;
					next_rd_wait = 2'h0;
					next_wr_phase = 2'h0;
					next_wr_last = 1'b0;
				end else if (timer == TIMER_W'(TIMEOUT_CYCLES)) begin
					next_state = FCL_ERROR;
				end
			end
			FCL_STREAM: begin
				// Reader: hold the address until the access time has passed
				if (rd_left != 24'h00_0000) begin
					if (rd_wait != FLASH_WAIT) begin
						next_rd_wait = rd_wait + 2'h1;
					end else if (fifo_in_ready) begin
						next_rd_addr = rd_addr + 26'h000_0001;
						next_rd_left = rd_left - 24'h00_0001;
						next_rd_wait = 2'h0;
					end
				end
				// Writer: data one cycle ahead of the rising strobe, held past its fall
				case (wr_phase)
					2'h0: begin
						if (fifo_out_valid) begin
							next_cfg.data = fifo_out.data;
							next_wr_last = fifo_out.last;
							next_wr_phase = 2'h1;
						end
					end
					2'h1: begin
						next_cfg.dclk = 1'b1;
						next_wr_phase = 2'h2;
					end
					default: begin
						next_cfg.dclk = 1'b0;
						next_wr_phase = 2'h0;
						if (wr_last) begin
							next_state = FCL_FINISH;
							next_timer = '0;
						end
					end
				endcase
				if (!nstatus_s) begin
					next_state = FCL_ERROR;
					next_cfg.dclk = 1'b0;
				end
			end
			FCL_FINISH: begin
				next_timer = timer + 20'h0_0001;
				if (done_s)
					next_state = FCL_DONE;
				else if (!nstatus_s || timer == TIMER_W'(TIMEOUT_CYCLES))
					next_state = FCL_ERROR;
			end
			default: next_state = FCL_IDLE;
		endcase
		next_flash_rd = (next_state == FCL_STREAM) && (next_rd_left != 24'h00_0000);
		next_load_led = (next_state == FCL_PULSE) || (next_state == FCL_WAIT_STATUS)
			|| (next_state == FCL_STREAM) || (next_state == FCL_FINISH);
		next_done_n = (next_state != FCL_DONE);
		next_error = (next_state == FCL_ERROR);
		next_jtag_en = !ext_present;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= FCL_IDLE;
			timer <= '0;
			page <= PAGE_FACTORY;
			cur_page <= PAGE_FACTORY;
			settle <= 3'h0;
			boot_pend <= 1'b1;
			rd_addr <= '0;
			rd_left <= 24'h00_0000;
			rd_wait <= 2'h0;
			wr_phase <= 2'h0;
			wr_last <= 1'b0;
			flash_rd <= 1'b0;
			cfg_out <= '{nconfig: 1'b1, dclk: 1'b0, data: 16'h0000};
			page_indicator <= IND_RESET;
			load_led <= 1'b0;
			config_done_led_n <= 1'b1;
			error_led <= 1'b0;
			onboard_jtag_en <= 1'b0;
			lvl_d <= '1;
		end else begin
			state <= next_state;
			timer <= next_timer;
			page <= next_page;
			cur_page <= next_cur_page;
			settle <= next_settle;
			boot_pend <= next_boot_pend;
			rd_addr <= next_rd_addr;
			rd_left <= next_rd_left;
			rd_wait <= next_rd_wait;
			wr_phase <= next_wr_phase;
			wr_last <= next_wr_last;
			flash_rd <= next_flash_rd;
			cfg_out <= next_cfg;
			page_indicator <= next_indicator;
			load_led <= next_load_led;
			config_done_led_n <= next_done_n;
			error_led <= next_error;
			onboard_jtag_en <= next_jtag_en;
			lvl_d <= lvl;
		end
	end

	// Flash is only read; write enable stays inactive
	assign flash_req = '{addr: rd_addr, ce_n: !flash_rd, oe_n: !flash_rd, we_n: 1'b1};
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	chk_indicator_onehot: assert property ($onehot(~page_indicator))
		else $error("page indicator not one lit");
	chk_page_step: assert property (sel_press |=> page ==
		(($past(page) == PAGE_USER2) ? PAGE_FACTORY : $past(page) + 2'h1))
		else $error("page did not step");
	chk_indicator_follows: assert property (sel_press |=>
		page_indicator == ~(IND_ONE << page)) else $error("indicator lags page");
	chk_load_page: assert property ((idle_like && load_press && !boot_go) |=>
		state == FCL_PULSE && cur_page == $past(page) && !cfg_out.nconfig)
		else $error("load press did not start on shown page");
	chk_boot_page: assert property (boot_go |=>
		cur_page == ($past(sw_on) ? PAGE_USER1 : PAGE_FACTORY) && state == FCL_PULSE)
		else $error("power-up load used wrong page");
	chk_active_lamp: assert property ((state == FCL_STREAM || state == FCL_PULSE)
		|-> load_led && config_done_led_n) else $error("active lamp off while loading");
	chk_done_lamp: assert property ((state == FCL_FINISH && done_s) |=>
		!config_done_led_n && !load_led && !error_led) else $error("done lamp not lit");
	chk_error_lamp: assert property ((state == FCL_STREAM && !nstatus_s) |=>
		error_led ##1 (error_led || state != FCL_ERROR)) else $error("error lamp not lit");
	chk_jtag_off: assert property (ext_present |=> !onboard_jtag_en)
		else $error("onboard master left on");
	chk_strobe_data: assert property ($rose(cfg_out.dclk) |->
		$stable(cfg_out.data) ##1 (!cfg_out.dclk && $stable(cfg_out.data)))
		else $error("config data moved around strobe");
	chk_word_path: assert property ((fifo_out_valid && fifo_out_ready && nstatus_s)
		|=> cfg_out.data == $past(fifo_out.data) ##1 (cfg_out.dclk || error_led))
		else $error("fifo word not presented");
	chk_press_once: assert property (load_press |=> !load_press [*2])
		else $error("button produced repeated press");

	cov_load_done: cover property (state == FCL_FINISH ##1 state == FCL_DONE);
	cov_stream_error: cover property (state == FCL_STREAM ##1 state == FCL_ERROR);
	cov_user2_load: cover property (load_press && idle_like && page == PAGE_USER2);
	cov_fifo_full: cover property (fifo_in_valid && !fifo_in_ready);
endmodule

// ===== test/fcl_partner.sv
// Behavioural flash memory and configuration target facing the loader.
// Assumes the loader changes its outputs just after the rising clock edge.
`timescale 1ns/10ps
module fcl_partner #(
	parameter int STATUS_DELAY = 5,
	parameter int DONE_WORDS = 16
) (
	// Clock
	input wire logic clock,
	// Flash side
	input fcl_pkg::fcl_flash_req_t flash_req,
	output logic [fcl_pkg::DATA_W-1:0] flash_data,
	// Target side
	input fcl_pkg::fcl_cfg_out_t cfg_out,
	output logic cfg_nstatus,
	output logic cfg_conf_done,
	// Bench control and capture
	input wire logic fail_status,
	output int word_count,
	output logic [fcl_pkg::DATA_W-1:0] last_word
);
	import fcl_pkg::*;
	logic [DATA_W-1:0] held = 16'h0000;
	logic dclk_q = 1'b0;
	int since_cfg = 0;

	// Word encodes page and offset, so a wrong page or order shows up
	always_comb begin
		if (!flash_req.ce_n && !flash_req.oe_n) begin
			flash_data = {flash_req.addr[25:24], flash_req.addr[13:0]};
		end else begin
			// Released bus toggles every cycle rather than keep a stale word
			flash_data = ~held;
		end
	end

	// Done rises once a whole image has been strobed in
	assign cfg_conf_done = cfg_out.nconfig && (word_count >= DONE_WORDS);
	assign cfg_nstatus = !fail_status && cfg_out.nconfig && (since_cfg >= STATUS_DELAY);

	always @(posedge clock) begin
		held <= flash_data;
		dclk_q <= cfg_out.dclk;
		if (cfg_out.nconfig === 1'b0) begin
			word_count <= 0;
			since_cfg <= 0;
		end else begin
			if (since_cfg < 1000) begin
				since_cfg <= since_cfg + 1;
			end
			if (cfg_out.dclk && !dclk_q) begin
				word_count <= word_count + 1;
				last_word <= cfg_out.data;
			end
		end
	end
endmodule

// ===== test/flash_config_loader_tb_top.sv
// Self-checking bench for the flash configuration loader.
// Assumes shortened debounce, timeout and image length.
`timescale 1ns/10ps
module flash_config_loader_tb_top;
	import fcl_pkg::*;
	localparam int DEB = 4;
	localparam int TMO = 64;
	localparam int IMG = 16;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic config_load_button_n = 1'b1;
	logic page_select_button_n = 1'b1;
	logic user_image_sw_n = 1'b0;
	logic ext_jtag_present_n = 1'b1;
	logic fail_status = 1'b0;
	fcl_flash_req_t flash_req;
	logic [DATA_W-1:0] flash_data;
	fcl_cfg_out_t cfg_out;
	logic cfg_nstatus;
	logic cfg_conf_done;
	logic [2:0] page_indicator;
	logic load_led;
	logic config_done_led_n;
	logic error_led;
	logic onboard_jtag_en;
	int word_count;
	logic [DATA_W-1:0] last_word;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int nconf_lows = 0;
	int n0;
	int cnt;
	logic [2:0] steps [5] = '{3'h5, 3'h3, 3'h6, 3'h5, 3'h3};

	fcl_loader #(.DEBOUNCE_CYCLES(DEB), .TIMEOUT_CYCLES(TMO),
		.IMAGE_LEN(24'(IMG))) fcl_loader_i (
		.clock, .rstn, .config_load_button_n, .page_select_button_n,
		.user_image_sw_n, .ext_jtag_present_n, .flash_req, .flash_data,
		.cfg_out, .cfg_nstatus, .cfg_conf_done, .page_indicator, .load_led,
		.config_done_led_n, .error_led, .onboard_jtag_en
	);

	fcl_partner #(.DONE_WORDS(IMG)) fcl_partner_i (
		.clock, .flash_req, .flash_data, .cfg_out, .cfg_nstatus, .cfg_conf_done,
		.fail_status, .word_count, .last_word
	);

	always #20 clock = ~clock;

	always @(negedge clock) begin
		if (cfg_out.nconfig === 1'b0) begin
			nconf_lows++;
		end
	end

	// Run is well under a thousand cycles; this only cuts a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Called at a falling edge; release also outlasts the filter
	task automatic press(ref logic pin, input int len);
		pin = 1'b0;
		repeat (len) @(negedge clock);
		pin = 1'b1;
		repeat (DEB + 8) @(negedge clock);
	endtask

	task automatic wait_words(input int n);
		for (int i = 0; i < 400 && word_count < n; i++) begin
			@(negedge clock);
		end
	endtask

	task automatic wait_error();
		cnt = 0;
		while (error_led !== 1'b1 && cnt < 400) begin
			@(negedge clock);
			cnt++;
		end
	endtask

	task automatic t_boot(input logic [1:0] page);
		n0 = nconf_lows;
		wait_words(3);
		check(nconf_lows - n0, NCONFIG_LOW);
		check(load_led, 1'b1);
		check(last_word, {page, 14'(word_count - 1)});
		check(page_indicator, 3'h6);
		check(config_done_led_n, 1'b1);
		check(onboard_jtag_en, 1'b1);
	endtask

	task automatic t_error_stream();
		fail_status = 1'b1;
		wait_error();
		check(error_led, 1'b1);
		check(load_led, 1'b0);
		n0 = word_count;
		repeat (10) @(negedge clock);
		check(word_count, n0);
		fail_status = 1'b0;
	endtask

	task automatic t_jtag();
		ext_jtag_present_n = 1'b0;
		repeat (10) @(negedge clock);
		check(onboard_jtag_en, 1'b0);
		ext_jtag_present_n = 1'b1;
		repeat (10) @(negedge clock);
		check(onboard_jtag_en, 1'b1);
	endtask

	task automatic t_select();
		press(page_select_button_n, 2);
		check(page_indicator, 3'h6);
		foreach (steps[i]) begin
			press(page_select_button_n, DEB + 8);
			check(page_indicator, steps[i]);
		end
	endtask

	task automatic t_load();
		n0 = nconf_lows;
		press(config_load_button_n, DEB + 8);
		wait_words(3);
		check(nconf_lows - n0, NCONFIG_LOW);
		check(last_word, {2'h2, 14'(word_count - 1)});
		n0 = nconf_lows;
		press(config_load_button_n, DEB + 8);
		check(nconf_lows - n0, 0);
		check(load_led, 1'b1);
	endtask

	// Target never reports ready, so the wait for status must give up
	task automatic t_timeout();
		fail_status = 1'b1;
		wait_error();
		press(config_load_button_n, DEB + 8);
		check(load_led, 1'b1);
		wait_error();
		check(error_led, 1'b1);
		check(cnt + 2 * (DEB + 8) >= NCONFIG_LOW + TMO, 1'b1);
		fail_status = 1'b0;
	endtask

	// Clean load runs to the end of the image and lights the done lamp
	task automatic t_done();
		cnt = 0;
		while (config_done_led_n !== 1'b0 && cnt < 400) begin
			@(negedge clock);
			cnt++;
		end
		check(config_done_led_n, 1'b0);
		check(load_led, 1'b0);
		check(error_led, 1'b0);
		check(word_count, IMG);
		check(last_word, {2'h0, 14'(IMG - 1)});
	endtask

	initial begin
		repeat (2) @(negedge clock);
		rstn = 1'b1;
		t_boot(2'h1);
		t_error_stream();
		t_jtag();
		t_select();
		t_load();
		t_timeout();
		// Second reset mid-run with the power-up switch off
		rstn = 1'b0;
		user_image_sw_n = 1'b1;
		repeat (2) @(negedge clock);
		rstn = 1'b1;
		t_boot(2'h0);
		t_done();
		print_verdict();
	end
endmodule
